/* File: scz_secure_zone_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - eight sets of 24-bit read/write passwords
// - read password reads, write password both
// - one active password until next, reset or revocation
// - wrong password decrements counter, zero kills
// - four key sets assignable to zones
// - failed check leaves authentication, decrements counter
// - match from cipher authenticates, refills counter
// - encryption only from authentication, same set
// - encryption holds; failed check drops both
// - encrypted zones need encryption mode
// - passwords travel encrypted while authenticated
// - bad checksum in secure mode rejects write, revokes privileges
// - checksum readback revokes privileges
// - modify-forbidden blocks all zone writes
// - program-only zones only clear bits
// - page lock byte masks page bytes
// - lock byte self-locks, only clears bits
// - locked zones store first byte only
// - buffered write limited to eight bytes
// - interrupted buffered write recovered at power-up
// - five-cycle flag check, poll-time busy
// - standard mode after power-up
// - counters step four- or eight-trial sequence
module scz_secure_zone_ctrl #(
  parameter int unsigned AT_BUSY_CYC = scz_pkg::AT_POLL_CYC,
  parameter int unsigned REC_BUSY_CYC = scz_pkg::RECOVER_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire scz_pkg::scz_cmd_s cmd,
  output logic cmd_ok,
  output logic cmd_fail,
  output logic wr_ok,
  output logic [7:0] wr_data,
  output logic [3:0] rd_grant,
  output logic [3:0] wr_grant,
  input wire logic at_flag,
  output logic recover_req,
  output logic busy,
  output logic ready,
  output logic auth_active,
  output logic enc_active,
  output logic pw_crypt
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers
  scz_pkg::scz_state_s st_reg; // Registered state
  scz_pkg::scz_state_s st_next; // Next state
  logic eight; // Eight-trial counting selected
  logic [7:0] cur_pac; // Counter of the password presented
  logic [23:0] cur_pw; // Stored password presented against
  logic [7:0] cur_aac; // Counter of the key set named
  logic [7:0] f_access; // Access byte of the addressed zone
  logic f_allow; // Filter verdict
  logic [7:0] f_data; // Filtered byte
  logic zone_wr_ok; // Privileges allow writing the zone
  logic mac_bad; // Write in secure mode with bad checksum

  // Next counter value after a failed trial
  function automatic logic [7:0] cnt_dec(input logic [7:0] c,
                                         input logic e);
    cnt_dec = e ? {c[6:0], 1'b0} : {c[6:4], 1'b0, c[2:0], 1'b0};
  endfunction

  // Whether privileges open a zone for reading or writing
  function automatic logic zone_ok(input logic [13:0] cfg,
                                   input scz_pkg::scz_priv_s p,
                                   input logic write);
    logic [7:0] ar;
    logic need_pw;
    logic need_auth;
    logic pw_ok;
    logic ks_ok;
    ar = cfg[7:0];
    need_pw = write ? !(ar[scz_pkg::AR_PM0] && ar[scz_pkg::AR_PM1])
                    : !ar[scz_pkg::AR_PM0];
    need_auth = write ? !(ar[scz_pkg::AR_AM1] && ar[scz_pkg::AR_AM0])
                      : !ar[scz_pkg::AR_AM1];
    pw_ok = p.pw_valid && (p.pw_idx == cfg[scz_pkg::CFG_PW_LSB +: 3])
            && (p.pw_wr || !write);
    ks_ok = p.auth && (p.key == cfg[scz_pkg::CFG_KEY_LSB +: 2]);
    zone_ok = (!need_pw || pw_ok) && (!need_auth || ks_ok)
              && (ar[scz_pkg::AR_ER] || (p.enc && ks_ok))
              && (!write || ar[scz_pkg::AR_MDF]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand lookups
  always_comb begin
    eight = !st_reg.dcr[scz_pkg::DCR_ETA];
    cur_pac = cmd.wr_pw ? st_reg.pacw[cmd.idx] : st_reg.pacr[cmd.idx];
    cur_pw = cmd.wr_pw ? st_reg.pww[cmd.idx] : st_reg.pwr[cmd.idx];
    cur_aac = st_reg.aac[cmd.key];
    f_access = st_reg.zcfg[cmd.zone][7:0];
    zone_wr_ok = zone_ok(st_reg.zcfg[cmd.zone], st_reg.priv, 1'b1);
    mac_bad = (st_reg.priv.auth || st_reg.priv.enc) && !cmd.mac_ok;
  end

  // Byte option filter
  scz_write_filter u_filter (
    .access(f_access),
    .byte_off(cmd.byte_off),
    .byte_num(cmd.byte_num),
    .old_byte(cmd.old_byte),
    .new_byte(cmd.new_byte),
    .lock_byte(cmd.lock_byte),
    .anti_tear(cmd.anti_tear),
    .allow(f_allow),
    .data(f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.cmd_ok = 1'b0;
    st_next.cmd_fail = 1'b0;
    st_next.wr_ok = 1'b0;
    st_next.rdata = '0;
    // Poll window countdown
    if (st_reg.busy_cnt != '0) begin
      st_next.busy_cnt = st_reg.busy_cnt - 1'b1;
    end
    // Power-up flag check and recovery
    unique case (st_reg.phase)
      scz_pkg::PH_CHECK: begin
        if (st_reg.pup_cnt == scz_pkg::PUP_LAST) begin
          if (at_flag) begin
            st_next.phase = scz_pkg::PH_RECOVER;
            st_next.recover_req = 1'b1;
            st_next.busy_cnt = scz_pkg::scz_busy_t'(REC_BUSY_CYC);
          end else begin
            st_next.phase = scz_pkg::PH_READY;
          end
        end else begin
          st_next.pup_cnt = st_reg.pup_cnt + 3'h1;
        end
      end
      scz_pkg::PH_RECOVER: begin
        // Recovery ends with its poll window
        if (st_reg.busy_cnt <= scz_pkg::scz_busy_t'(1)) begin
          st_next.phase = scz_pkg::PH_READY;
          st_next.recover_req = 1'b0;
        end
      end
      scz_pkg::PH_READY: begin
      end
    endcase
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr[7:5])
        scz_pkg::RGN_LOW: begin
          if (reg_addr == scz_pkg::REG_DCR) begin
            st_next.dcr = reg_wdata[7:0];
          end else if (reg_addr[4] && reg_addr[1:0] == 2'h0) begin
            st_next.zcfg[reg_addr[3:2]] = reg_wdata[13:0];
          end
        end
        scz_pkg::RGN_PWW: begin
          st_next.pww[reg_addr[4:2]] = reg_wdata[23:0];
        end
        scz_pkg::RGN_PWR: begin
          st_next.pwr[reg_addr[4:2]] = reg_wdata[23:0];
        end
        scz_pkg::RGN_PAC: begin
          st_next.pacw[reg_addr[4:2]] = reg_wdata[15:8];
          st_next.pacr[reg_addr[4:2]] = reg_wdata[7:0];
        end
        scz_pkg::RGN_AAC: begin
          if (!reg_addr[4]) begin
            st_next.aac[reg_addr[3:2]] = reg_wdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Register reads, data valid one cycle later
    if (reg_rd) begin
      unique case (reg_addr[7:5])
        scz_pkg::RGN_LOW: begin
          if (reg_addr == scz_pkg::REG_DCR) begin
            st_next.rdata = {24'h00_0000, st_reg.dcr};
          end else if (reg_addr == scz_pkg::REG_STATUS) begin
            st_next.rdata = {8'h00, st_reg.wr_grant, st_reg.rd_grant, 3'h0,
                             st_reg.phase, st_reg.recover_req,
                             st_reg.busy_cnt != '0, st_reg.priv};
          end else if (reg_addr[4] && reg_addr[1:0] == 2'h0) begin
            st_next.rdata = {18'h0_0000, st_reg.zcfg[reg_addr[3:2]]};
          end
        end
        scz_pkg::RGN_PWW: begin
          st_next.rdata = {8'h00, st_reg.pww[reg_addr[4:2]]};
        end
        scz_pkg::RGN_PWR: begin
          st_next.rdata = {8'h00, st_reg.pwr[reg_addr[4:2]]};
        end
        scz_pkg::RGN_PAC: begin
          st_next.rdata = {16'h0000, st_reg.pacw[reg_addr[4:2]],
                           st_reg.pacr[reg_addr[4:2]]};
        end
        scz_pkg::RGN_AAC: begin
          if (!reg_addr[4]) begin
            st_next.rdata = {24'h00_0000, st_reg.aac[reg_addr[3:2]]};
          end
        end
        default: begin
        end
      endcase
    end
    // Security commands; these win over a register write
    if (cmd_valid) begin
      if (!ready) begin
        st_next.cmd_fail = 1'b1;
      end else begin
        unique case (cmd.op)
          scz_pkg::OP_VPW: begin
            // Any presentation replaces the active password
            st_next.priv.pw_valid = 1'b0;
            if (cur_pac != scz_pkg::CNT_DEAD && cmd.pw == cur_pw) begin
              st_next.priv.pw_valid = 1'b1;
              st_next.priv.pw_idx = cmd.idx;
              st_next.priv.pw_wr = cmd.wr_pw;
              st_next.cmd_ok = 1'b1;
              if (cmd.wr_pw) begin
                st_next.pacw[cmd.idx] = scz_pkg::CNT_FULL;
              end else begin
                st_next.pacr[cmd.idx] = scz_pkg::CNT_FULL;
              end
            end else begin
              st_next.cmd_fail = 1'b1;
              if (cur_pac != scz_pkg::CNT_DEAD) begin
                if (cmd.wr_pw) begin
                  st_next.pacw[cmd.idx] = cnt_dec(cur_pac, eight);
                end else begin
                  st_next.pacr[cmd.idx] = cnt_dec(cur_pac, eight);
                end
              end
            end
          end
          scz_pkg::OP_VAUTH: begin
            if (cur_aac != scz_pkg::CNT_DEAD && cmd.match) begin
              st_next.priv.auth = 1'b1;
              st_next.priv.enc = 1'b0;
              st_next.priv.key = cmd.key;
              st_next.aac[cmd.key] = scz_pkg::CNT_FULL;
              st_next.cmd_ok = 1'b1;
            end else begin
              st_next.priv.auth = 1'b0;
              st_next.priv.enc = 1'b0;
              st_next.cmd_fail = 1'b1;
              if (cur_aac != scz_pkg::CNT_DEAD) begin
                st_next.aac[cmd.key] = cnt_dec(cur_aac, eight);
              end
            end
          end
          scz_pkg::OP_VENC: begin
            if (cur_aac != scz_pkg::CNT_DEAD && cmd.match
                && st_reg.priv.auth && st_reg.priv.key == cmd.key) begin
              st_next.priv.enc = 1'b1;
              st_next.cmd_ok = 1'b1;
            end else begin
              st_next.priv.auth = 1'b0;
              st_next.priv.enc = 1'b0;
              st_next.cmd_fail = 1'b1;
              if (cur_aac != scz_pkg::CNT_DEAD) begin
                st_next.aac[cmd.key] = cnt_dec(cur_aac, eight);
              end
            end
          end
          scz_pkg::OP_RDMAC: begin
            st_next.priv = '0;
            st_next.cmd_ok = 1'b1;
          end
          scz_pkg::OP_WRITE: begin
            if (mac_bad) begin
              st_next.priv = '0;
              st_next.cmd_fail = 1'b1;
            end else if (zone_wr_ok && f_allow) begin
              st_next.wr_ok = 1'b1;
              st_next.wr_data = f_data;
              st_next.cmd_ok = 1'b1;
              if (cmd.anti_tear) begin
                st_next.busy_cnt = scz_pkg::scz_busy_t'(AT_BUSY_CYC);
              end
            end else begin
              st_next.cmd_fail = 1'b1;
            end
          end
          default: begin
            st_next.cmd_fail = 1'b1;
          end
        endcase
      end
    end
    // Per-zone grants from the current privileges
    for (int z = 0; z < scz_pkg::NUM_ZONE; z++) begin
      st_next.rd_grant[z] = zone_ok(st_reg.zcfg[z], st_reg.priv, 1'b0);
      st_next.wr_grant[z] = zone_ok(st_reg.zcfg[z], st_reg.priv, 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset gives standard mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= scz_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st_reg.rdata;
  assign cmd_ok = st_reg.cmd_ok;
  assign cmd_fail = st_reg.cmd_fail;
  assign wr_ok = st_reg.wr_ok;
  assign wr_data = st_reg.wr_data;
  assign rd_grant = st_reg.rd_grant;
  assign wr_grant = st_reg.wr_grant;
  assign recover_req = st_reg.recover_req;
  assign busy = st_reg.busy_cnt != '0;
  assign ready = st_reg.phase == scz_pkg::PH_READY && !busy;
  assign auth_active = st_reg.priv.auth;
  assign enc_active = st_reg.priv.enc;
  assign pw_crypt = st_reg.priv.auth || st_reg.priv.enc;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_pw_fail_drop: assert property (
    cmd_valid && ready && cmd.op == scz_pkg::OP_VPW && cmd.pw != cur_pw
    |=> cmd_fail && !st_reg.priv.pw_valid)
    else $error("wrong password left a password active");

  chk_pac_step: assert property (
    cmd_valid && ready && cmd.op == scz_pkg::OP_VPW && cmd.wr_pw
    && cmd.pw != cur_pw && cur_pac != scz_pkg::CNT_DEAD
    |=> st_reg.pacw[$past(cmd.idx)] == cnt_dec($past(cur_pac), $past(eight)))
    else $error("password counter stepped wrongly");

  chk_pac_dead: assert property (
    cmd_valid && ready && cmd.op == scz_pkg::OP_VPW
    && cur_pac == scz_pkg::CNT_DEAD |=> cmd_fail && !cmd_ok)
    else $error("exhausted password was accepted");

  chk_pw_hold: assert property (
    st_reg.priv.pw_valid && !cmd_valid
    |=> st_reg.priv.pw_valid && $stable(st_reg.priv.pw_idx))
    else $error("active password lost without a command");

  chk_auth_fail: assert property (
    cmd_valid && ready && !cmd.match
    && (cmd.op == scz_pkg::OP_VAUTH || cmd.op == scz_pkg::OP_VENC)
    |=> !auth_active && !enc_active && cmd_fail)
    else $error("failed key check kept a secure mode");

  chk_enc_from_auth: assert property (
    $rose(enc_active) |-> $past(auth_active) && auth_active)
    else $error("encryption entered without authentication");

  chk_mac_revoke: assert property (
    cmd_valid && ready && cmd.op == scz_pkg::OP_WRITE && mac_bad
    |=> !wr_ok && !auth_active && !enc_active && !st_reg.priv.pw_valid)
    else $error("bad checksum write not rejected");

  chk_rdmac_revoke: assert property (
    cmd_valid && ready && cmd.op == scz_pkg::OP_RDMAC
    |=> st_reg.priv == '0)
    else $error("checksum readback kept privileges");

  chk_mdf_block: assert property (
    cmd_valid && cmd.op == scz_pkg::OP_WRITE
    && !f_access[scz_pkg::AR_MDF] |=> !wr_ok)
    else $error("write reached a read-only zone");

  chk_pgo_clear: assert property (
    f_allow && !f_access[scz_pkg::AR_PGO]
    |-> (f_data & ~cmd.old_byte) == 8'h00)
    else $error("program-only byte gained a one");

  chk_lock_mask: assert property (
    !f_access[scz_pkg::AR_WLM] && cmd.byte_off != 3'h0
    && !cmd.lock_byte[cmd.byte_off] |-> !f_allow)
    else $error("locked page byte allowed");

  chk_single_byte: assert property (
    !f_access[scz_pkg::AR_WLM] && cmd.byte_num != 4'h0 |-> !f_allow)
    else $error("locked zone stored a later byte");

  chk_pup_check: assert property (
    st_reg.phase == scz_pkg::PH_CHECK && st_reg.pup_cnt != scz_pkg::PUP_LAST
    |=> st_reg.phase == scz_pkg::PH_CHECK && !ready)
    else $error("flag check ended early");

  chk_reset_std: assert property (
    $fell(rst) |-> st_reg.priv == '0 && !pw_crypt)
    else $error("reset left privileges");

  cov_pw_ok: cover property (
    cmd_valid && cmd.op == scz_pkg::OP_VPW ##1 cmd_ok);
  cov_enc_on: cover property ($rose(enc_active));
  cov_recover: cover property ($rose(recover_req) ##1 recover_req);
  cov_at_write: cover property (
    cmd_valid && cmd.op == scz_pkg::OP_WRITE && cmd.anti_tear ##1 wr_ok);

endmodule

`default_nettype wire

/* File: scz_pkg.sv */
`default_nettype none

package scz_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes of the protection resources
  localparam int NUM_PW = 8;
  localparam int NUM_KEY = 4;
  localparam int NUM_ZONE = 4;
  localparam int BUSY_W = 23;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: clock rate, poll windows, power-up flag check
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned AT_POLL_MS = 18;
  localparam int unsigned RECOVER_MS = 14;
  localparam int unsigned AT_POLL_CYC = AT_POLL_MS * 1000 * CLK_MHZ;
  localparam int unsigned RECOVER_CYC = RECOVER_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] PUP_LAST = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_DCR = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [2:0] RGN_LOW = 3'h0;
  localparam logic [2:0] RGN_PWW = 3'h1;
  localparam logic [2:0] RGN_PWR = 3'h2;
  localparam logic [2:0] RGN_PAC = 3'h3;
  localparam logic [2:0] RGN_AAC = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int DCR_ETA = 4;
  localparam int AR_PM1 = 7;
  localparam int AR_PM0 = 6;
  localparam int AR_AM1 = 5;
  localparam int AR_AM0 = 4;
  localparam int AR_ER = 3;
  localparam int AR_WLM = 2;
  localparam int AR_MDF = 1;
  localparam int AR_PGO = 0;
  localparam int CFG_PW_LSB = 8;
  localparam int CFG_KEY_LSB = 12;
  localparam logic [3:0] AT_MAX_LAST = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] CNT_FULL = 8'hFF;
  localparam logic [7:0] CNT_DEAD = 8'h00;
  localparam logic [23:0] PW_RST = 24'hFF_FFFF;
  localparam logic [13:0] CFG_RST = 14'h3FFF;
  localparam logic [7:0] DCR_RST = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [BUSY_W-1:0] scz_busy_t;

  // Security commands from the command decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_VPW = 3'h1,
    OP_VENC = 3'h2,
    OP_VAUTH = 3'h3,
    OP_WRITE = 3'h6,
    OP_RDMAC = 3'h7
  } scz_op_e;

  // Power-up sequence
  typedef enum logic [1:0] {
    PH_CHECK = 2'h0,
    PH_RECOVER = 2'h1,
    PH_READY = 2'h3
  } scz_phase_e;

  // One command with its operands
  typedef struct packed {
    scz_op_e op;
    logic [2:0] idx;
    logic wr_pw;
    logic [1:0] key;
    logic [23:0] pw;
    logic match;
    logic mac_ok;
    logic [1:0] zone;
    logic [2:0] byte_off;
    logic [3:0] byte_num;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    logic [7:0] lock_byte;
    logic anti_tear;
  } scz_cmd_s;

  // Volatile privileges
  typedef struct packed {
    logic pw_valid;
    logic [2:0] pw_idx;
    logic pw_wr;
    logic auth;
    logic enc;
    logic [1:0] key;
  } scz_priv_s;

  // Whole state of the controller
  typedef struct packed {
    scz_priv_s priv;
    scz_phase_e phase;
    logic [2:0] pup_cnt;
    scz_busy_t busy_cnt;
    logic recover_req;
    logic [7:0] dcr;
    logic [NUM_ZONE-1:0][13:0] zcfg;
    logic [NUM_PW-1:0][23:0] pww;
    logic [NUM_PW-1:0][23:0] pwr;
    logic [NUM_PW-1:0][7:0] pacw;
    logic [NUM_PW-1:0][7:0] pacr;
    logic [NUM_KEY-1:0][7:0] aac;
    logic [31:0] rdata;
    logic cmd_ok;
    logic cmd_fail;
    logic wr_ok;
    logic [7:0] wr_data;
    logic [NUM_ZONE-1:0] rd_grant;
    logic [NUM_ZONE-1:0] wr_grant;
  } scz_state_s;

  localparam scz_state_s STATE_RST = '{
    phase: PH_CHECK,
    dcr: DCR_RST,
    zcfg: {NUM_ZONE{CFG_RST}},
    pww: {NUM_PW{PW_RST}},
    pwr: {NUM_PW{PW_RST}},
    pacw: {NUM_PW{CNT_FULL}},
    pacr: {NUM_PW{CNT_FULL}},
    aac: {NUM_KEY{CNT_FULL}},
    default: '0
  };

endpackage

`default_nettype wire

/* File: scz_write_filter.sv */
`timescale 1ns/1ps
`default_nettype none

// Byte write filter for one user-zone byte
module scz_write_filter (
  input wire logic [7:0] access, // Zone access byte, options active low
  input wire logic [2:0] byte_off, // Byte position inside the 8-byte page
  input wire logic [3:0] byte_num, // Byte index inside the command
  input wire logic [7:0] old_byte, // Stored value of the byte
  input wire logic [7:0] new_byte, // Value the host sends
  input wire logic [7:0] lock_byte, // Lowest byte of the page
  input wire logic anti_tear, // Buffered write selected
  output logic allow, // Byte may be written
  output logic [7:0] data // Value to store
);

  ////////////////////////////////////////////////////////////////////////////
  // Option checks, applied in order
  always_comb begin
    allow = 1'b1;
    data = new_byte;
    // Read-only zone
    if (!access[scz_pkg::AR_MDF]) begin
      allow = 1'b0;
    end
    // Buffered writes carry at most one page
    if (anti_tear && byte_num > scz_pkg::AT_MAX_LAST) begin
      allow = 1'b0;
    end
    // Page lock option
    if (!access[scz_pkg::AR_WLM]) begin
      // Only the first byte of a command is stored
      if (byte_num != 4'h0) begin
        allow = 1'b0;
      end
      if (byte_off == 3'h0) begin
        // Lock byte guards itself and only loses ones
        if (!old_byte[0]) begin
          allow = 1'b0;
        end
        data = old_byte & new_byte;
      end else if (!lock_byte[byte_off]) begin
        allow = 1'b0;
      end
    end
    // Program-only: bits may only be cleared
    if (!access[scz_pkg::AR_PGO]) begin
      data = old_byte & data;
    end
  end

endmodule

`default_nettype wire

/* File: scz_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side: cipher verdict and the nonvolatile tear flag
module scz_host_model (
  input wire logic tear, // Power was lost in a buffered write
  input wire logic key_good, // Host holds the right secret seed
  output logic at_flag, // Tear flag seen at power-up
  output logic match // Host and device challenges agree
);
  // Challenge from random value and seed agrees only with the right seed
  assign match = key_good;
  // Flag stays set only after a torn destination write
  assign at_flag = tear;
endmodule

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0; // Bench clock
  logic rst = 1'b1; // Async reset
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cmd_valid = 1'b0;
  logic tear = 1'b0;
  logic key_good = 1'b0;
  scz_pkg::scz_cmd_s cmd = '0;
  scz_pkg::scz_cmd_s c; // Command being built
  logic [31:0] reg_rdata, rv;
  logic cmd_ok, cmd_fail, wr_ok, recover_req, busy, ready, at_flag, match;
  logic auth_active, enc_active, pw_crypt;
  logic [7:0] wr_data, exp_cnt;
  logic [3:0] rd_grant, wr_grant;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  scz_host_model u_scz_host_model (.tear(tear), .key_good(key_good),
    .at_flag(at_flag), .match(match));

  // Poll windows shortened to 20 cycles
  scz_secure_zone_ctrl #(.AT_BUSY_CYC(20), .REC_BUSY_CYC(20))
    u_scz_secure_zone_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ok(cmd_ok), .cmd_fail(cmd_fail), .wr_ok(wr_ok), .wr_data(wr_data),
    .rd_grant(rd_grant), .wr_grant(wr_grant), .at_flag(at_flag),
    .recover_req(recover_req), .busy(busy), .ready(ready),
    .auth_active(auth_active), .enc_active(enc_active), .pw_crypt(pw_crypt));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // One command; answer pulses are settled on return
  task automatic send(input scz_pkg::scz_cmd_s x);
    x.match = match;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= x;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic complete_run;
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (7) @(posedge clk);
    #1 check(32'(ready), 32'h1);
    rd(8'h04);
    check(rv & 32'h0000_19FF, 32'h0000_1800);
    // Zone 1 needs password set 1 for reading and writing
    wr(8'h14, 32'h0000_013F);
    // Four-trial counter walk on write password 0
    c = '0;
    c.op = scz_pkg::OP_VPW;
    c.wr_pw = 1'b1;
    exp_cnt = 8'hFF;
    for (int i = 0; i < 4; i++) begin
      send(c);
      check(32'(cmd_fail), 32'h1);
      exp_cnt = exp_cnt & ~(8'h11 << i);
      rd(8'h60);
      check(rv, {16'h0000, exp_cnt, 8'hFF});
    end
    c.pw = scz_pkg::PW_RST;
    send(c);
    check(32'(cmd_fail), 32'h1);
    // Read password 1, then write password 2 replaces it
    c.idx = 3'h1;
    c.wr_pw = 1'b0;
    send(c);
    check(32'(cmd_ok), 32'h1);
    rd(8'h04);
    check(rv & 32'h0000_01F0, 32'h0000_0120);
    check({24'h0, wr_grant, rd_grant}, 32'h0000_00DF);
    c.idx = 3'h2;
    c.wr_pw = 1'b1;
    send(c);
    rd(8'h04);
    check(rv & 32'h0000_01F0, 32'h0000_0150);
    check({24'h0, wr_grant, rd_grant}, 32'h0000_00DD);
    // Eight-trial setting
    wr(8'h00, 32'h0000_00EF);
    c.idx = 3'h3;
    c.wr_pw = 1'b0;
    c.pw = 24'h00_0001;
    send(c);
    rd(8'h6C);
    check(rv, 32'h0000_FFFE);
    // Page lock on zone 0, mask D9
    wr(8'h10, 32'h0000_3FFB);
    c = '0;
    c.op = scz_pkg::OP_WRITE;
    c.mac_ok = 1'b1;
    c.lock_byte = 8'hD9;
    c.new_byte = 8'h55;
    c.byte_off = 3'h1;
    send(c);
    check(32'(wr_ok), 32'h0);
    c.byte_off = 3'h3;
    send(c);
    check({23'h0, wr_ok, wr_data}, 32'h0000_0155);
    c.byte_num = 4'h1;
    send(c);
    check(32'(wr_ok), 32'h0);
    c.byte_num = 4'h0;
    c.byte_off = 3'h0;
    c.lock_byte = 8'hD8;
    send(c);
    check(32'(wr_ok), 32'h0);
    // Program-only clears bits only
    wr(8'h10, 32'h0000_3FFE);
    c.old_byte = 8'h0F;
    c.new_byte = 8'hF3;
    send(c);
    check({23'h0, wr_ok, wr_data}, 32'h0000_0103);
    // Modify forbidden
    wr(8'h10, 32'h0000_3FFD);
    send(c);
    check(32'(wr_ok), 32'h0);
    wr(8'h10, 32'h0000_3FFF);
    // Authentication with key set 3
    c = '0;
    c.op = scz_pkg::OP_VAUTH;
    c.key = 2'h3;
    send(c);
    rd(8'h8C);
    check(rv, 32'h0000_00FE);
    key_good = 1'b1;
    send(c);
    check({30'h0, auth_active, pw_crypt}, 32'h3);
    c.op = scz_pkg::OP_VENC;
    send(c);
    check(32'(enc_active), 32'h1);
    key_good = 1'b0;
    send(c);
    check({30'h0, auth_active, enc_active}, 32'h0);
    key_good = 1'b1;
    c.op = scz_pkg::OP_VAUTH;
    send(c);
    c = '0;
    c.op = scz_pkg::OP_WRITE;
    send(c);
    check({30'h0, cmd_fail, auth_active}, 32'h2);
    c.op = scz_pkg::OP_VAUTH;
    c.key = 2'h3;
    send(c);
    c.op = scz_pkg::OP_RDMAC;
    send(c);
    check(32'(auth_active), 32'h0);
    // Buffered write holds the poll window
    c = '0;
    c.op = scz_pkg::OP_WRITE;
    c.anti_tear = 1'b1;
    send(c);
    check({30'h0, busy, ready}, 32'h2);
    repeat (22) @(posedge clk);
    #1 check(32'(ready), 32'h1);
    // Torn write recovered at the next power-up
    tear = 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (7) @(posedge clk);
    #1 check({30'h0, recover_req, ready}, 32'h2);
    // Commands during recovery are refused
    send(c);
    check({30'h0, cmd_fail, wr_ok}, 32'h2);
    complete_run();
  end
endmodule

`default_nettype wire
